// *** include/fbp_map.svh ***
// register offsets, command codes and timing counts for the protection host
`ifndef FBP_MAP_SVH
`define FBP_MAP_SVH
`define FBP_REG_CTRL 4'h0
`define FBP_REG_ADDR 4'h4
`define FBP_REG_DATA 4'h8
`define FBP_REG_STAT 4'hC
`define FBP_CTRL_GO 0
`define FBP_CTRL_OP_LSB 1
`define FBP_CTRL_OP_MSB 4
`define FBP_CTRL_BYTE 8
`define FBP_CTRL_SET_LSB 12
`define FBP_CTRL_SET_MSB 15
`define FBP_STAT_BUSY 0
`define FBP_STAT_ACTIVE 1
`define FBP_STAT_XMB 2
`define FBP_UL1_X8 24'h000AAA
`define FBP_UL2_X8 24'h000555
`define FBP_UL1_X16 24'h000555
`define FBP_UL2_X16 24'h0002AA
`define FBP_D_AA 8'hAA
`define FBP_D_55 8'h55
`define FBP_D_A0 8'hA0
`define FBP_D_80 8'h80
`define FBP_D_30 8'h30
`define FBP_D_90 8'h90
`define FBP_D_00 8'h00
`define FBP_D_01 8'h01
`define FBP_D_25 8'h25
`define FBP_D_03 8'h03
`define FBP_D_29 8'h29
`define FBP_D_FF 8'hFF
`define FBP_SET_LOCKREG 8'h40
`define FBP_SET_PASSWD 8'h60
`define FBP_SET_NVPB 8'hC0
`define FBP_SET_NVLOCK 8'h50
`define FBP_SET_VOLPB 8'hE0
`define FBP_SET_XMB 8'h88
`define FBP_CLK_MHZ 40
`define FBP_GAP_NS 1000
`define FBP_GAP_CYC ((`FBP_GAP_NS * `FBP_CLK_MHZ + 999) / 1000)
`define FBP_PULSE_CYC 3
`endif

// *** include/fbp_pkg.sv ***
// types shared by the protection host
package fbp_pkg;
  typedef enum logic [3:0] {
    FBP_OP_ENTER = 4'h0,
    FBP_OP_EXIT = 4'h1,
    FBP_OP_PROG = 4'h2,
    FBP_OP_READ = 4'h3,
    FBP_OP_CLRALL = 4'h4,
    FBP_OP_UNLOCK = 4'h5,
    FBP_OP_XMB_EXIT = 4'h6,
    FBP_OP_WRITE1 = 4'h7
  } fbp_op_e;
  typedef logic [23:0] fbp_addr_t;
  typedef logic [15:0] fbp_data_t;
endpackage

// *** hdl/fbp_bus_cycle.sv ***
// one asynchronous flash bus cycle, write or read, timed in clocks
`timescale 1ns/10ps
`include "fbp_map.svh"
module fbp_bus_cycle #(
  parameter int PULSE_CYC = `FBP_PULSE_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // request
  input wire logic start_in,
  input wire logic write_in,
  input wire fbp_pkg::fbp_addr_t addr_in,
  input wire fbp_pkg::fbp_data_t wdata_in,
  output logic done_out,
  output fbp_pkg::fbp_data_t rdata_out,
  // flash pins
  output fbp_pkg::fbp_addr_t fl_addr_out,
  output logic fl_ce_n_out,
  output logic fl_oe_n_out,
  output logic fl_we_n_out,
  output fbp_pkg::fbp_data_t fl_dq_out,
  output logic fl_dq_oe_out,
  input wire fbp_pkg::fbp_data_t fl_dq_in
);
  import fbp_pkg::*;
  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin
      $error("fbp_bus_cycle: PULSE_CYC out of range");
    end
  end
  typedef enum logic [3:0] {
    FBC_IDLE = 4'b0001,
    FBC_SETUP = 4'b0010,
    FBC_PULSE = 4'b0100,
    FBC_HOLD = 4'b1000
  } fbc_state_e;
  fbc_state_e state_r;
  logic [7:0] cnt_r;
  logic wr_r;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= FBC_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
    end else begin
      case (state_r)
        FBC_IDLE: begin
          if (start_in) begin
            state_r <= FBC_SETUP;
            wr_r <= write_in;
          end
        end
        FBC_SETUP: begin
          state_r <= FBC_PULSE;
          cnt_r <= 8'(PULSE_CYC);
        end
        FBC_PULSE: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            state_r <= FBC_HOLD;
          end
        end
        FBC_HOLD: state_r <= FBC_IDLE;
        default: state_r <= FBC_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      fl_addr_out <= 24'h000000;
      fl_dq_out <= 16'h0000;
      fl_ce_n_out <= 1'b1;
      fl_oe_n_out <= 1'b1;
      fl_we_n_out <= 1'b1;
      fl_dq_oe_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      if (state_r == FBC_IDLE && start_in) begin
        fl_addr_out <= addr_in;
        fl_dq_out <= wdata_in;
        fl_dq_oe_out <= write_in;
        fl_ce_n_out <= 1'b0;
      end
      if (state_r == FBC_SETUP) begin
        fl_we_n_out <= !wr_r;
        fl_oe_n_out <= wr_r;
      end
      if (state_r == FBC_PULSE && cnt_r == 8'h01) begin
        fl_we_n_out <= 1'b1;
        fl_oe_n_out <= 1'b1;
        if (!wr_r) begin
          rdata_out <= fl_dq_in;
        end
      end
      if (state_r == FBC_HOLD) begin
        fl_ce_n_out <= 1'b1;
        fl_dq_oe_out <= 1'b0;
      end
    end
  end
  assign done_out = (state_r == FBC_HOLD);
endmodule

// *** hdl/fbp_host.sv ***
// wishbone-driven host sequencer for flash block protection commands
// Function
// - enter a set with three unlock writes, code 40/60/C0/50/E0/88
// - leave a set with any-address writes 90 then 00
// - leave extended block with unlock cycles plus 90, then 00
// - lock, password and status reads are plain bus reads
// - volatile set: A0 then block address with 00 sets, 01 clears
// - password programmed by repeated A0 writes per portion
// - unlock is 00/25, 00/03, portions, 00/29
// - at least 1 us between unlock commands
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "fbp_map.svh"
module fbp_host #(
  parameter int PULSE_CYC = `FBP_PULSE_CYC,
  parameter int GAP_CYC = `FBP_GAP_CYC,
  parameter logic [63:0] PW_DEFAULT = 64'hFFFFFFFFFFFFFFFF
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // flash pins
  output fbp_pkg::fbp_addr_t fl_addr_out,
  output logic fl_ce_n_out,
  output logic fl_oe_n_out,
  output logic fl_we_n_out,
  output logic fl_byte_n_out,
  output fbp_pkg::fbp_data_t fl_dq_out,
  output logic fl_dq_oe_out,
  input wire fbp_pkg::fbp_data_t fl_dq_in
);
  import fbp_pkg::*;
  initial begin
    if (GAP_CYC < 1 || GAP_CYC > 65535) begin
      $error("fbp_host: GAP_CYC out of range");
    end
  end
  typedef enum logic [4:0] {
    FBH_IDLE = 5'b00001,
    FBH_ISSUE = 5'b00010,
    FBH_WAIT = 5'b00100,
    FBH_GAP = 5'b01000,
    FBH_DONE = 5'b10000
  } fbh_state_e;

  // software-visible registers
  logic [15:0] ctrl_r;
  fbp_addr_t addr_r;
  logic [63:0] data_r;
  logic busy_r;
  logic set_active_r;
  logic xmb_r;
  logic [7:0] set_code_r;
  fbp_data_t rd_r;
  // sequencer
  fbh_state_e state_r;
  logic [3:0] step_r;
  logic [3:0] nsteps_r;
  logic [15:0] gap_r;
  logic [15:0] unl_gap_r;
  logic cyc_start;
  logic cyc_done;
  fbp_data_t cyc_rdata;
  fbp_addr_t cur_addr;
  fbp_data_t cur_data;
  logic cur_wr;
  logic byte_mode;
  fbp_op_e op;

  assign byte_mode = ctrl_r[`FBP_CTRL_BYTE];
  assign op = fbp_op_e'(ctrl_r[`FBP_CTRL_OP_MSB:`FBP_CTRL_OP_LSB]);
  assign fl_byte_n_out = !byte_mode;

  // unlock addresses differ between x8 and x16
  function automatic fbp_addr_t unl_addr(input logic first, input logic b8);
    if (b8) begin
      unl_addr = first ? `FBP_UL1_X8 : `FBP_UL2_X8;
    end else begin
      unl_addr = first ? `FBP_UL1_X16 : `FBP_UL2_X16;
    end
  endfunction

  function automatic fbp_data_t pw_part(input logic [63:0] pw,
                                        input logic [3:0] idx,
                                        input logic b8);
    if (b8) begin
      pw_part = {8'h00, pw[8*idx[2:0] +: 8]};
    end else begin
      pw_part = pw[16*idx[1:0] +: 16];
    end
  endfunction

  // step count per operation
  always_comb begin
    case (op)
      FBP_OP_ENTER: nsteps_r = 4'd3;
      FBP_OP_EXIT: nsteps_r = 4'd2;
      FBP_OP_XMB_EXIT: nsteps_r = 4'd4;
      FBP_OP_PROG: nsteps_r = 4'd2;
      FBP_OP_CLRALL: nsteps_r = 4'd2;
      FBP_OP_READ: nsteps_r = 4'd1;
      FBP_OP_WRITE1: nsteps_r = 4'd1;
      FBP_OP_UNLOCK: nsteps_r = byte_mode ? 4'd11 : 4'd7;
      default: nsteps_r = 4'd1;
    endcase
  end

  // address, data and direction of the current step
  always_comb begin
    cur_addr = addr_r;
    cur_data = data_r[15:0];
    cur_wr = 1'b1;
    case (op)
      FBP_OP_ENTER, FBP_OP_XMB_EXIT: begin
        // high data byte is don't-care on the device, drive zero
        if (step_r == 4'd0) begin
          cur_addr = unl_addr(1'b1, byte_mode);
          cur_data = {8'h00, `FBP_D_AA};
        end else if (step_r == 4'd1) begin
          cur_addr = unl_addr(1'b0, byte_mode);
          cur_data = {8'h00, `FBP_D_55};
        end else if (step_r == 4'd2) begin
          cur_addr = unl_addr(1'b1, byte_mode);
          cur_data = (op == FBP_OP_ENTER) ? {8'h00, set_code_r}
                                          : {8'h00, `FBP_D_90};
        end else begin
          cur_data = {8'h00, `FBP_D_00};
        end
      end
      FBP_OP_EXIT: begin
        cur_data = (step_r == 4'd0) ? {8'h00, `FBP_D_90}
                                    : {8'h00, `FBP_D_00};
      end
      FBP_OP_PROG: begin
        // second cycle carries block address, portion index or data
        if (step_r == 4'd0) begin
          cur_data = {8'h00, `FBP_D_A0};
        end
      end
      FBP_OP_CLRALL: begin
        if (step_r == 4'd0) begin
          cur_data = {8'h00, `FBP_D_80};
        end else begin
          cur_addr = 24'h000000;
          cur_data = {8'h00, `FBP_D_30};
        end
      end
      FBP_OP_READ: cur_wr = 1'b0;
      FBP_OP_UNLOCK: begin
        cur_addr = 24'h000000;
        if (step_r == 4'd0) begin
          cur_data = {8'h00, `FBP_D_25};
        end else if (step_r == 4'd1) begin
          cur_data = {8'h00, `FBP_D_03};
        end else if (step_r == nsteps_r - 4'd1) begin
          cur_data = {8'h00, `FBP_D_29};
        end else begin
          // portions at ascending addresses from 00
          cur_addr = {20'h00000, step_r - 4'd2};
          cur_data = pw_part(data_r, step_r - 4'd2, byte_mode);
        end
      end
      default: cur_wr = 1'b1;
    endcase
  end

  assign cyc_start = (state_r == FBH_ISSUE);

  // sequencer
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= FBH_IDLE;
      step_r <= 4'd0;
      gap_r <= 16'h0000;
    end else begin
      case (state_r)
        FBH_IDLE: begin
          step_r <= 4'd0;
          if (busy_r) begin
            // hold back an unlock until the spacing has passed
            state_r <= (op == FBP_OP_UNLOCK && unl_gap_r != 16'h0000)
                       ? FBH_IDLE : FBH_ISSUE;
          end
        end
        FBH_ISSUE: state_r <= FBH_WAIT;
        FBH_WAIT: begin
          if (cyc_done) begin
            if (step_r == nsteps_r - 4'd1) begin
              state_r <= FBH_GAP;
              gap_r <= (op == FBP_OP_UNLOCK) ? 16'(GAP_CYC) : 16'h0000;
            end else begin
              step_r <= step_r + 4'd1;
              state_r <= FBH_ISSUE;
            end
          end
        end
        FBH_GAP: begin
          // unlock takes about 1 us to complete on the device
          if (gap_r == 16'h0000) begin
            state_r <= FBH_DONE;
          end else begin
            gap_r <= gap_r - 16'h0001;
          end
        end
        FBH_DONE: state_r <= FBH_IDLE;
        default: state_r <= FBH_IDLE;
      endcase
    end
  end

  // spacing timer between unlock commands
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      unl_gap_r <= 16'h0000;
    end else if (state_r == FBH_DONE && op == FBP_OP_UNLOCK) begin
      unl_gap_r <= 16'(GAP_CYC);
    end else if (unl_gap_r != 16'h0000) begin
      unl_gap_r <= unl_gap_r - 16'h0001;
    end
  end

  // mode tracking: reset assumes read mode, main array
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      set_active_r <= 1'b0;
      xmb_r <= 1'b0;
      rd_r <= 16'h0000;
    end else if (state_r == FBH_DONE) begin
      case (op)
        FBP_OP_ENTER: begin
          // set code chooses the command group
          if (set_code_r == `FBP_SET_XMB) begin
            xmb_r <= 1'b1;
          end else begin
            set_active_r <= 1'b1;
          end
        end
        FBP_OP_EXIT: set_active_r <= 1'b0;
        FBP_OP_XMB_EXIT: xmb_r <= 1'b0;
        FBP_OP_READ: rd_r <= cyc_rdata;
        default: rd_r <= rd_r;
      endcase
    end
  end

  // wishbone registers; answers one cycle after the request
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
      ctrl_r <= 16'h0000;
      addr_r <= 24'h000000;
      data_r <= PW_DEFAULT;
      busy_r <= 1'b0;
      set_code_r <= 8'h00;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      if (state_r == FBH_DONE) begin
        busy_r <= 1'b0;
      end
      if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
        wb_dat_out <= 32'h00000000;
        if (wb_we_in) begin
          case (wb_adr_in)
            `FBP_REG_CTRL: begin
              // writes while busy are dropped to keep the sequence intact
              if (!busy_r && wb_sel_in[0] && wb_sel_in[1]) begin
                ctrl_r <= wb_dat_in[15:0];
                busy_r <= wb_dat_in[`FBP_CTRL_GO];
                set_code_r <= wb_dat_in[23:16];
              end
            end
            `FBP_REG_ADDR: if (!busy_r) addr_r <= wb_dat_in[23:0];
            `FBP_REG_DATA: if (!busy_r) data_r[31:0] <= wb_dat_in;
            `FBP_REG_STAT: if (!busy_r) data_r[63:32] <= wb_dat_in;
            default: busy_r <= busy_r;
          endcase
        end else begin
          case (wb_adr_in)
            `FBP_REG_CTRL: wb_dat_out <= {8'h00, set_code_r, ctrl_r};
            `FBP_REG_ADDR: wb_dat_out <= {8'h00, addr_r};
            `FBP_REG_DATA: wb_dat_out <= {16'h0000, rd_r};
            `FBP_REG_STAT: wb_dat_out <= {29'h00000000, xmb_r,
                                          set_active_r, busy_r};
            default: wb_dat_out <= 32'h00000000;
          endcase
        end
      end
    end
  end

  fbp_bus_cycle #(
    .PULSE_CYC(PULSE_CYC)
  ) u_cycle (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(cyc_start),
    .write_in(cur_wr),
    .addr_in(cur_addr),
    .wdata_in(cur_data),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .fl_addr_out(fl_addr_out),
    .fl_ce_n_out(fl_ce_n_out),
    .fl_oe_n_out(fl_oe_n_out),
    .fl_we_n_out(fl_we_n_out),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe_out(fl_dq_oe_out),
    .fl_dq_in(fl_dq_in)
  );

  a_enter_three: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_r == FBH_ISSUE && op == FBP_OP_ENTER) |-> step_r < 4'd3)
    else $error("enter sequence exceeded three cycles");
  a_unlock_len: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_r == FBH_ISSUE && op == FBP_OP_UNLOCK)
      |-> step_r < (byte_mode ? 4'd11 : 4'd7))
    else $error("unlock sequence length wrong");
  a_unlock_gap: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state_r == FBH_IDLE && busy_r && op == FBP_OP_UNLOCK
     && unl_gap_r != 16'h0000) |=> state_r == FBH_IDLE)
    else $error("unlock issued inside spacing");
  a_exit_data: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (cyc_start && op == FBP_OP_EXIT) |-> cur_data[7:0] ==
      ((step_r == 4'd0) ? `FBP_D_90 : `FBP_D_00))
    else $error("exit sequence data wrong");
  a_read_noop: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (cyc_start && op == FBP_OP_READ) |-> !cur_wr)
    else $error("read op issued a write");
  a_xmb_exit_seq: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (cyc_start && op == FBP_OP_XMB_EXIT) |-> cur_data[7:0] ==
      ((step_r == 4'd0) ? `FBP_D_AA : (step_r == 4'd1) ? `FBP_D_55 :
       (step_r == 4'd2) ? `FBP_D_90 : `FBP_D_00))
    else $error("extended block exit data wrong");
endmodule

// *** dv/fbp_flash_model.sv ***
// behavioural flash device answering the block protection commands
`timescale 1ns/10ps
module fbp_flash_model #(
  parameter int GAP_NS = 1000,
  parameter int PWLOCK_BIT = 2
) (
  // flash pins from the host
  input wire logic [23:0] fl_addr_in,
  input wire logic fl_ce_n_in,
  input wire logic fl_oe_n_in,
  input wire logic fl_we_n_in,
  input wire logic fl_byte_n_in,
  input wire logic [15:0] fl_dq_in,
  // read data towards the host
  output logic [15:0] fl_dq_out
);
  logic [7:0] mode_r = 8'h00; // power-up in read mode
  logic [15:0] lock_r = 16'hFFFF;
  logic [63:0] pw_r = 64'hFFFFFFFFFFFFFFFF;
  logic [63:0] ent_r;
  logic nv_r [0:255];
  logic vol_r [0:255];
  logic nvlock_r = 1'b1;
  int gap_err_r = 0;
  int blocked_r = 0;
  int pwc_r = 0;
  realtime last_unl_r = -1.0e6;
  logic [15:0] ha_r [0:2];
  logic [7:0] hd_r [0:2];
  logic [15:0] a, u1, u2, rd, last_r;
  logic [7:0] d, blk;
  logic [2:0] idx;
  logic b8;
  initial begin
    last_r = 16'h0000;
    foreach (nv_r[i]) begin
      nv_r[i] = 1'b1;
      vol_r[i] = 1'b1;
    end
    foreach (hd_r[i]) begin
      hd_r[i] = 8'h00;
      ha_r[i] = 16'h0000;
    end
  end
  assign b8 = !fl_byte_n_in;
  assign blk = fl_addr_in[23:16];
  assign idx = b8 ? fl_addr_in[2:0] : {1'b0, fl_addr_in[1:0]};
  assign u1 = b8 ? 16'h0AAA : 16'h0555;
  assign u2 = b8 ? 16'h0555 : 16'h02AA;
  always_comb begin
    // set modes other than 88 replace array reads at every address, so no block is in reach
    case (mode_r)
      8'h40: rd = lock_r;
      8'h60: rd = !lock_r[PWLOCK_BIT] ? 16'hFFFF :
        b8 ? {8'h00, pw_r[idx*8 +: 8]} : pw_r[idx*16 +: 16];
      8'hC0: rd = {15'h0000, nv_r[blk]};
      8'hE0: rd = {15'h0000, vol_r[blk]};
      8'h50: rd = {15'h0000, nvlock_r};
      default: rd = 16'h5AA5 ^ fl_addr_in[15:0];
    endcase
  end
  // released bus shows the inverse of the last value, never a stale copy
  assign fl_dq_out = (!fl_ce_n_in && !fl_oe_n_in) ? rd : ~last_r;
  always @(posedge fl_oe_n_in) last_r <= rd;
  always @(posedge fl_we_n_in) begin
    if (!fl_ce_n_in) begin
      a = fl_addr_in[15:0];
      d = fl_dq_in[7:0];
      // still finishing an unlock: no command may arrive yet
      if (pwc_r == 0 && $realtime - last_unl_r < GAP_NS) gap_err_r++;
      if (pwc_r == 1) begin
        pwc_r = (d == 8'h03) ? 2 : 0;
      end else if (pwc_r > 1 && pwc_r < (b8 ? 10 : 6)) begin
        if (b8) ent_r[idx*8 +: 8] = d;
        else ent_r[idx*16 +: 16] = fl_dq_in;
        pwc_r = pwc_r + 1;
      end else if (pwc_r != 0) begin
        if (d == 8'h29 && ent_r == pw_r) nvlock_r = 1'b1;
        last_unl_r = $realtime;
        pwc_r = 0;
      end else if (mode_r == 8'h00 && ha_r[1] == u1 && hd_r[1] == 8'hAA &&
          ha_r[0] == u2 && hd_r[0] == 8'h55 && a == u1 &&
          (d inside {8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0, 8'h88})) begin
        mode_r = d;
      end else if (mode_r == 8'h88 && ha_r[2] == u1 && hd_r[2] == 8'hAA &&
          ha_r[1] == u2 && hd_r[1] == 8'h55 && ha_r[0] == u1 &&
          hd_r[0] == 8'h90 && d == 8'h00) begin
        mode_r = 8'h00;
      end else if (mode_r != 8'h88 && hd_r[0] == 8'h90 && d == 8'h00) begin
        mode_r = 8'h00;
      end else if (mode_r != 8'h00 && hd_r[0] == 8'hA0) begin
        case (mode_r)
          8'h40: lock_r = lock_r & fl_dq_in;
          8'h60: if (b8) pw_r[idx*8 +: 8] = pw_r[idx*8 +: 8] & d;
            else pw_r[idx*16 +: 16] = pw_r[idx*16 +: 16] & fl_dq_in;
          8'hC0: if (d == 8'h00) nv_r[blk] = 1'b0;
          8'hE0: vol_r[blk] = d[0];
          8'h50: if (d == 8'h00) nvlock_r = 1'b0;
          default: ;
        endcase
      end else if (mode_r == 8'h00 && hd_r[0] == 8'hA0 && ha_r[0] == u1 &&
          hd_r[1] == 8'h55 && hd_r[2] == 8'hAA) begin
        // array program into a protected block is dropped
        if (!nv_r[blk] || !vol_r[blk]) blocked_r = blocked_r + 1;
      end else if (mode_r == 8'hC0 && hd_r[0] == 8'h80 && d == 8'h30 &&
          a == 16'h0000) begin
        if (nvlock_r) begin
          foreach (nv_r[i]) nv_r[i] = 1'b0;
          foreach (nv_r[i]) nv_r[i] = 1'b1;
        end
      end else if (mode_r == 8'h60 && d == 8'h25 && a == 16'h0000) begin
        if ($realtime - last_unl_r < GAP_NS) gap_err_r++;
        else pwc_r = 1;
      end
      ha_r[2] = ha_r[1];
      hd_r[2] = hd_r[1];
      ha_r[1] = ha_r[0];
      hd_r[1] = hd_r[0];
      ha_r[0] = a;
      hd_r[0] = d;
    end
  end
endmodule

// *** dv/testbench.sv ***
// self-checking bench: protection host against the flash model
`timescale 1ns/10ps
module testbench;
  import fbp_pkg::*;
  typedef struct {
    fbp_op_e op;
    logic byt;
    logic [7:0] set;
    logic [23:0] addr;
    logic [31:0] data;
    logic [7:0] md;
    logic [15:0] rd;
  } fbp_tb_row_s;
  localparam fbp_op_e op_en = FBP_OP_ENTER;
  localparam fbp_op_e op_ex = FBP_OP_EXIT;
  localparam fbp_op_e op_pr = FBP_OP_PROG;
  localparam fbp_op_e op_rd = FBP_OP_READ;
  localparam fbp_op_e op_ca = FBP_OP_CLRALL;
  localparam fbp_op_e op_ul = FBP_OP_UNLOCK;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r, q;
  logic wb_ack, f_ce_n, f_oe_n, f_we_n, f_byte_n, h_oe;
  fbp_addr_t f_addr;
  fbp_data_t h_dq, m_dq, dq_w;
  int mismatches = 0;
  int tests_run = 0;
  fbp_tb_row_s rows[$];
  assign dq_w = h_oe ? h_dq : m_dq;
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  fbp_host i_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_dat_w),
    .wb_dat_out(wb_dat_r), .wb_ack_out(wb_ack), .fl_addr_out(f_addr),
    .fl_ce_n_out(f_ce_n), .fl_oe_n_out(f_oe_n), .fl_we_n_out(f_we_n),
    .fl_byte_n_out(f_byte_n), .fl_dq_out(h_dq), .fl_dq_oe_out(h_oe),
    .fl_dq_in(dq_w));
  fbp_flash_model i_flash (.fl_addr_in(f_addr), .fl_ce_n_in(f_ce_n),
    .fl_oe_n_in(f_oe_n), .fl_we_n_in(f_we_n), .fl_byte_n_in(f_byte_n),
    .fl_dq_in(dq_w), .fl_dq_out(m_dq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  // op runs to completion; the status poll covers the unlock wait too
  task automatic run_op(input fbp_tb_row_s r);
    int n;
    xfer(1'b1, 4'h4, {8'h00, r.addr});
    xfer(1'b1, 4'h8, r.data);
    xfer(1'b1, 4'hC, 32'hFFFFFFFF);
    xfer(1'b1, 4'h0, {8'h00, r.set, 7'h00, r.byt, 3'h0, r.op, 1'b1});
    n = 0;
    do begin
      xfer(1'b0, 4'hC, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    if (n >= 3000) mismatches++;
    if (r.op == op_rd) xfer(1'b0, 4'h8, 32'h0);
  endtask
  task automatic add(input fbp_op_e op, input logic b, input logic [23:0] a,
                     input logic [31:0] d, input logic [7:0] md,
                     input logic [15:0] rd);
    rows.push_back('{op, b, (op == op_en) ? md : 8'h00, a, d, md, rd});
  endtask
  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'h40, 16'h0);
    add(op_pr, 1'b0, 24'h0, 32'hFFFD, 8'h40, 16'h0);
    add(op_rd, 1'b0, 24'h0, 32'h0, 8'h40, 16'hFFFD);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'h60, 16'h0);
    add(op_rd, 1'b0, 24'h1, 32'h0, 8'h60, 16'hFFFF);
    add(op_pr, 1'b0, 24'h1, 32'h1234, 8'h60, 16'h0);
    add(op_rd, 1'b0, 24'h1, 32'h0, 8'h60, 16'h1234);
    add(op_rd, 1'b0, 24'h0, 32'h0, 8'h60, 16'hFFFF);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b1, 24'h0, 32'h0, 8'hC0, 16'h0);
    add(op_rd, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0001);
    add(op_pr, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0);
    add(op_rd, 1'b0, 24'h31234, 32'h0, 8'hC0, 16'h0000);
    add(op_ca, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0);
    add(op_rd, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0001);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'h50, 16'h0);
    add(op_pr, 1'b0, 24'h0, 32'h0, 8'h50, 16'h0);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'hC0, 16'h0);
    add(op_pr, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0);
    add(op_ca, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0);
    add(op_rd, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0000);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(FBP_OP_WRITE1, 1'b0, 24'h555, 32'hAA, 8'h00, 16'h0);
    add(FBP_OP_WRITE1, 1'b0, 24'h2AA, 32'h55, 8'h00, 16'h0);
    add(FBP_OP_WRITE1, 1'b0, 24'h555, 32'hA0, 8'h00, 16'h0);
    add(FBP_OP_WRITE1, 1'b0, 24'h30000, 32'h34, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'h60, 16'h0);
    add(op_ul, 1'b0, 24'h0, 32'h1234FFFF, 8'h60, 16'h0);
    add(op_ul, 1'b0, 24'h0, 32'h1234FFFF, 8'h60, 16'h0);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'hC0, 16'h0);
    add(op_ca, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0);
    add(op_rd, 1'b0, 24'h30000, 32'h0, 8'hC0, 16'h0001);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'h40, 16'h0);
    add(op_pr, 1'b0, 24'h0, 32'hFFF9, 8'h40, 16'h0);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'h60, 16'h0);
    add(op_rd, 1'b0, 24'h1, 32'h0, 8'h60, 16'hFFFF);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b1, 24'h0, 32'h0, 8'hE0, 16'h0);
    add(op_pr, 1'b0, 24'h50000, 32'h0, 8'hE0, 16'h0);
    add(op_rd, 1'b0, 24'h50000, 32'h0, 8'hE0, 16'h0000);
    add(op_pr, 1'b0, 24'h50000, 32'h1, 8'hE0, 16'h0);
    add(op_rd, 1'b0, 24'h50000, 32'h0, 8'hE0, 16'h0001);
    add(op_ex, 1'b0, 24'h0, 32'h0, 8'h00, 16'h0);
    add(op_en, 1'b1, 24'h0, 32'h0, 8'h88, 16'h0);
    add(op_ex, 1'b1, 24'h0, 32'h0, 8'h88, 16'h0);
    add(FBP_OP_XMB_EXIT, 1'b1, 24'h0, 32'h0, 8'h00, 16'h0);
    foreach (rows[i]) begin
      run_op(rows[i]);
      if (rows[i].op == op_rd) begin
        check(q[15:0], rows[i].rd);
      end
      check({8'h00, i_flash.mode_r}, {8'h00, rows[i].md});
      $display("row %0d done", i);
    end
    check(16'(i_flash.gap_err_r), 16'h0000);
    check(16'(i_flash.blocked_r), 16'h0001);
    add(op_en, 1'b0, 24'h0, 32'h0, 8'hC0, 16'h0);
    run_op(rows[$]);
    xfer(1'b0, 4'hC, 32'h0);
    check(q[15:0] & 16'h0002, 16'h0002);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({12'h000, f_ce_n, f_oe_n, f_we_n, h_oe}, 16'h000E);
    xfer(1'b0, 4'hC, 32'h0);
    check(q[15:0], 16'h0000);
    $display("reset test done");
    stop_test();
  end
endmodule
